// *** timer_channel_regs.sv ***
// APB register slice of one 16-bit timer channel: mask, status, snapshot, compare, capture
// Summary of operation
// - Mask bit 2 is read/write and lets the overflow interrupt through when one.
// - Mask bit 1 is read/write and lets the second compare-match interrupt through when one.
// - Mask bit 0 is read/write and lets the first compare-match interrupt through when one.
// - A status flag is set by its event whatever the mask says.
// - Reading the snapshot register returns the counter value caught at the read in bits 15-0.
// - Two independent read/write 16-bit compare registers are compared with the counter.
// - Counter equal to the first or second compare value on a count step, or an overflow, sets its flag.
// - Reading the status register clears the flags, and writing a one to a status bit also clears that flag.
// - No DMA request leaves for an event whose mask bit is zero, even if DMA is enabled.
module timer_channel_regs
	import timer_regs_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [CNT_W-1:0] count_value,
	input wire logic count_step,
	input wire logic overflow_pulse,
	input wire logic capture_first_strobe,
	input wire logic [EVT_W-1:0] dma_enable,
	output logic [EVT_W-1:0] event_flags,
	output logic [EVT_W-1:0] dma_request,
	output logic irq
);
	typedef struct packed {
		logic [EVT_W-1:0] mask_r;
		logic [CNT_W-1:0] cmp_first_r;
		logic [CNT_W-1:0] cmp_second_r;
		logic [CNT_W-1:0] cap_first_r;
		logic [DATA_W-1:0] prdata_r;
	} regs_state_t;

	regs_state_t st_r;
	regs_state_t st_nxt;

	flag_bus_if #(.W(EVT_W)) fb ();

	logic setup_ph;
	logic access_ph;
	logic mapped;
	logic wr_done;
	logic rd_done;
	logic [EVT_W-1:0] events;
	logic [EVT_W-1:0] wr_clear;
	logic [EVT_W-1:0] rd_clear;
	logic [DATA_W-1:0] rd_word;

	event_flag_bank #(.W(EVT_W)) u_flags (
		.pclk(pclk),
		.presetn(presetn),
		.fb(fb)
	);

	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign mapped = (paddr == OFS_MASK) || (paddr == OFS_STATUS) ||
		(paddr == OFS_SNAPSHOT) || (paddr == OFS_CMP_FIRST) ||
		(paddr == OFS_CMP_SECOND) || (paddr == OFS_CAP_FIRST);
	assign wr_done = access_ph & pwrite & mapped;
	assign rd_done = access_ph & ~pwrite & mapped;

	// compare match on each counter step, overflow from the counter
	always_comb begin
		events = '0;
		events[BIT_MATCH_FIRST] = count_step & (count_value == st_r.cmp_first_r);
		events[BIT_MATCH_SECOND] = count_step & (count_value == st_r.cmp_second_r);
		events[BIT_OVERFLOW] = overflow_pulse;
	end

	// status read clears, write of one clears as well
	assign rd_clear = (rd_done && paddr == OFS_STATUS) ? {EVT_W{1'b1}} : '0;
	assign wr_clear = (wr_done && paddr == OFS_STATUS && pstrb[0]) ? pwdata[EVT_W-1:0] : '0;

	assign fb.evt = events;
	assign fb.clr = rd_clear | wr_clear;

	// Read word assembled in the setup phase, upper bits zero
	always_comb begin
		rd_word = '0;
		unique case (paddr)
			OFS_MASK: rd_word[EVT_W-1:0] = st_r.mask_r;
			OFS_STATUS: rd_word[EVT_W-1:0] = fb.flag;
			OFS_SNAPSHOT: rd_word[CNT_W-1:0] = count_value;
			OFS_CMP_FIRST: rd_word[CNT_W-1:0] = st_r.cmp_first_r;
			OFS_CMP_SECOND: rd_word[CNT_W-1:0] = st_r.cmp_second_r;
			OFS_CAP_FIRST: rd_word[CNT_W-1:0] = st_r.cap_first_r;
			default: rd_word = '0;
		endcase
	end

	always_comb begin
		st_nxt = st_r;
		// Read data latched at the setup edge, so the snapshot holds the counter at the read
		if (setup_ph && !pwrite) begin
			st_nxt.prdata_r = rd_word;
		end
		if (capture_first_strobe) begin
			st_nxt.cap_first_r = count_value;
		end
		if (wr_done) begin
			unique case (paddr)
				OFS_MASK: begin
					if (pstrb[0]) begin
						st_nxt.mask_r = pwdata[EVT_W-1:0];
					end
				end
				OFS_CMP_FIRST: begin
					// first compare value, byte lanes honoured
					if (pstrb[0]) begin
						st_nxt.cmp_first_r[7:0] = pwdata[7:0];
					end
					if (pstrb[1]) begin
						st_nxt.cmp_first_r[15:8] = pwdata[15:8];
					end
				end
				OFS_CMP_SECOND: begin
					// second compare value, byte lanes honoured
					if (pstrb[0]) begin
						st_nxt.cmp_second_r[7:0] = pwdata[7:0];
					end
					if (pstrb[1]) begin
						st_nxt.cmp_second_r[15:8] = pwdata[15:8];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r.mask_r <= MASK_RESET;
			st_r.cmp_first_r <= CMP_RESET;
			st_r.cmp_second_r <= CMP_RESET;
			st_r.cap_first_r <= CAP_RESET;
			st_r.prdata_r <= RDATA_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata_r;
	assign pready = 1'b1;
	assign pslverr = access_ph & ~mapped;
	assign event_flags = fb.flag;
	// flags set regardless of mask; mask gates only the request
	assign irq = |(fb.flag & st_r.mask_r);
	// DMA request gated by the mask
	assign dma_request = events & st_r.mask_r & dma_enable;
endmodule

// *** timer_regs_pkg.sv ***
// Register map, field positions and reset values of the timer channel register slice
package timer_regs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;
	localparam int EVT_W = 3;

	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_SNAPSHOT = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CMP_FIRST = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_CMP_SECOND = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CAP_FIRST = 8'h14;

	localparam int BIT_MATCH_FIRST = 0;
	localparam int BIT_MATCH_SECOND = 1;
	localparam int BIT_OVERFLOW = 2;

	localparam logic [EVT_W-1:0] MASK_RESET = 3'h0;
	localparam logic [EVT_W-1:0] FLAG_RESET = 3'h0;
	localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] SNAP_RESET = 16'h0000;
	localparam logic [CNT_W-1:0] CAP_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;
endpackage

// *** flag_bus_if.sv ***
// Event, clear and flag lines between the register slice and its flag bank
interface flag_bus_if #(parameter int W = 3);
	logic [W-1:0] evt;
	logic [W-1:0] clr;
	logic [W-1:0] flag;
	modport bank (input evt, input clr, output flag);
	modport owner (output evt, output clr, input flag);
endinterface

// *** event_flag_bank.sv ***
// Sticky event flags, set by hardware events and cleared by software
module event_flag_bank
	import timer_regs_pkg::*;
#(
	parameter int W = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	flag_bus_if.bank fb
);
	typedef struct packed {
		logic [W-1:0] flag_r;
	} bank_state_t;

	bank_state_t st_r;
	bank_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.flag_r = (st_r.flag_r & ~fb.clr) | fb.evt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign fb.flag = st_r.flag_r;
endmodule

// *** timer_regs_sva.sv ***
// Port checks of the timer channel register slice
module timer_regs_sva import timer_regs_pkg::*; (
	input wire logic pclk, presetn, psel, penable, pwrite, irq, count_step, overflow_pulse,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic [CNT_W-1:0] count_value,
	input wire logic [EVT_W-1:0] dma_enable, event_flags, dma_request
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire rd_st = acc && !pwrite && paddr == OFS_STATUS;
	chk_ovf_sets: assert property (overflow_pulse |=> event_flags[2])
		else $error("ovf flag");
	chk_ovf_dma: assert property (dma_request[2] |-> overflow_pulse && dma_enable[2])
		else $error("ovf dma");
	chk_match_dma: assert property (dma_request[1] |-> count_step && dma_enable[1])
		else $error("match dma");
	chk_irq_cause: assert property (irq |-> |event_flags)
		else $error("irq src");
	chk_flag_cause: assert property ($rose(event_flags[2]) |-> $past(overflow_pulse))
		else $error("flag src");
	chk_flag_hold: assert property (event_flags[2] && !acc |=> event_flags[2])
		else $error("flag hold");
	chk_read_clear: assert property (rd_st && !overflow_pulse |=> !event_flags[2])
		else $error("no clear");
	chk_snap_value: assert property (psel && !penable && !pwrite && paddr == OFS_SNAPSHOT
		|=> prdata == {16'h0000, $past(count_value)})
		else $error("snapshot");
endmodule
bind timer_channel_regs timer_regs_sva chk_i (.*);

// *** apb_host.sv ***
// Bus host model issuing register transfers
module apb_host import timer_regs_pkg::*; (
	input wire logic pclk, pready, pslverr,
	input wire logic [DATA_W-1:0] prdata,
	output logic psel, penable, pwrite,
	output logic [ADDR_W-1:0] paddr,
	output logic [DATA_W-1:0] pwdata,
	output logic [3:0] pstrb
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {psel, penable, pwrite, paddr, pwdata, pstrb} = {43'h0, 4'hF};
	task automatic xfer(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] r, e);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = {31'h0, pslverr};
		{psel, penable, paddr, pwdata} <= {2'h0, ~a, ~d};
	endtask
endmodule

// *** timer_channel_regs_test.sv ***
// Self-checking bench of the timer channel register slice
module timer_channel_regs_test import timer_regs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic count_step, overflow_pulse, capture_first_strobe;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, r, e;
	logic [3:0] pstrb;
	logic [CNT_W-1:0] count_value;
	logic [EVT_W-1:0] dma_enable, event_flags, dma_request;
	int bad_count, checked;
	typedef struct {logic [7:0] a; logic [31:0] w, x;} row_t;
	row_t rows[4] = '{'{OFS_MASK, 32'hFFFFFFFF, 32'h7}, '{OFS_CMP_FIRST, 32'hABCD0010, 32'h10},
		'{OFS_CMP_SECOND, 32'h5555AAAA, 32'hAAAA}, '{OFS_MASK, 32'h6, 32'h6}};
	timer_channel_regs DUT (.*);
	apb_host host (.*);
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	task chk(input logic [31:0] s, x, input string n);
		checked++;
		if (s !== x) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input string n);
		host.xfer(1'b0, a, 32'h0, r, e);
		chk(r, x, n);
	endtask
	task ev(input logic o, s, input logic [15:0] c, input logic [2:0] x);
		@(posedge pclk);
		overflow_pulse <= o;
		count_step <= s;
		count_value <= c;
		#1 chk(dma_request, x, "dma_request");
		@(posedge pclk);
		overflow_pulse <= 1'b0;
		count_step <= 1'b0;
		#1 chk(irq, |x, "irq");
	endtask
	task give_verdict;
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#100us;
		bad_count++;
		give_verdict;
	end
	initial begin
		{presetn, count_step, overflow_pulse, capture_first_strobe} = 4'h0;
		count_value = 16'h0000;
		dma_enable = 3'h7;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_MASK, 32'h0, "mask reset");
		foreach (rows[i]) begin
			host.xfer(1'b1, rows[i].a, rows[i].w, r, e);
			rd(rows[i].a, rows[i].x, "readback");
		end
		ev(1'b1, 1'b0, 16'h0000, 3'h4);
		rd(OFS_STATUS, 32'h4, "status");
		rd(OFS_STATUS, 32'h0, "status");
		ev(1'b0, 1'b1, 16'hAAAA, 3'h2);
		rd(OFS_STATUS, 32'h2, "status");
		ev(1'b0, 1'b1, 16'h0010, 3'h0);
		rd(OFS_STATUS, 32'h1, "status");
		count_value <= 16'hBEEF;
		// Counter moves after the setup edge; the read must keep the value seen at setup
		fork
			rd(OFS_SNAPSHOT, 32'hBEEF, "snapshot");
			begin
				repeat (2) @(posedge pclk);
				count_value <= 16'h1111;
			end
		join
		capture_first_strobe <= 1'b1;
		@(posedge pclk);
		capture_first_strobe <= 1'b0;
		count_value <= 16'h0000;
		rd(OFS_CAP_FIRST, 32'h1111, "capture");
		ev(1'b1, 1'b0, 16'h0000, 3'h4);
		chk({29'h0, event_flags}, 32'h4, "event_flags");
		host.xfer(1'b1, OFS_STATUS, 32'h4, r, e);
		rd(OFS_STATUS, 32'h0, "status write clear");
		// Reset in mid-run brings mask and compare back to zero
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_MASK, 32'h0, "mask reset");
		rd(OFS_CMP_SECOND, 32'h0, "compare reset");
		rd(8'h20, 32'h0, "unmapped");
		chk(e, 32'h1, "pslverr");
		give_verdict;
	end
endmodule
